// file: hw/fp_single_pkg.sv
/*
 * Package for the single-precision classify and denormalize unit.
 * Holds field layout, bias, exponent limits and the class encoding.
 * Assumes nothing of its surroundings beyond a SystemVerilog compiler.
 */
package fp_single_pkg;

    // --------------------------------------------------------------
    // Field layout
    // --------------------------------------------------------------
    localparam int SIGN_POS = 31;        // Sign bit position
    localparam int EXP_MSB = 30;         // Exponent field top
    localparam int EXP_LSB = 23;         // Exponent field bottom
    localparam int EXP_W = 8;            // Exponent width
    localparam int FRAC_W = 23;          // Stored fraction width
    localparam int QUIET_POS = 22;       // Top fraction bit

    // --------------------------------------------------------------
    // Exponent constants
    // --------------------------------------------------------------
    localparam int EXP_BIAS = 127;                   // Bias added to true exponent
    localparam int EXP_MAX = 255;                    // All-ones exponent
    localparam int NORM_MIN = 1;                     // Least normal biased exponent
    localparam int NORM_MAX = 254;                   // Largest normal biased exponent
    localparam int TRUE_MIN = NORM_MIN - EXP_BIAS;   // -126

    // Indefinite: negative quiet NaN with zero payload below the quiet bit
    localparam logic [31:0] INDEF_WORD = 32'hFFC00000;
    // Reset value of the result word
    localparam logic [31:0] RESULT_RST = 32'h00000000;

    // --------------------------------------------------------------
    // Carriers
    // --------------------------------------------------------------
    typedef enum logic [2:0] {
        CLS_ZERO, CLS_DENORMAL, CLS_NORMAL, CLS_INFINITY,
        CLS_QNAN, CLS_SNAN, CLS_INDEFINITE
    } fp_class_t;

    typedef struct packed {
        logic sign;
        logic [EXP_W-1:0] expField;
        logic [FRAC_W-1:0] frac;
    } fp_word_t;

    typedef struct packed {
        fp_class_t cls;       // Class of the operand
        logic negative;       // Sign as read
        logic isZero;         // Either signed zero
        logic isNan;          // Any NaN
    } fp_info_t;

endpackage : fp_single_pkg

// file: hw/fp_classify.sv
/*
 * Combinational classifier for one single-precision word.
 * Assumes the word is laid out as the package fp_word_t.
 */
`timescale 1ns/1ns
module fp_classify
    import fp_single_pkg::*;
(
    input wire fp_word_t word,
    output fp_info_t info
);

    // --------------------------------------------------------------
    // Field tests
    // --------------------------------------------------------------
    logic expZero;     // Exponent all zero
    logic expOnes;     // Exponent all ones
    logic fracZero;    // Fraction all zero

    assign expZero = (word.expField == EXP_W'(0));
    assign expOnes = (word.expField == EXP_W'(EXP_MAX));
    assign fracZero = (word.frac == FRAC_W'(0));

    // Exactly one class per encoding, plus sign and zero/NaN tests
    always_comb begin
        info.negative = word.sign;
        info.isZero = expZero && fracZero;
        info.isNan = expOnes && !fracZero;
        if (expZero && fracZero) begin
            info.cls = CLS_ZERO;
        end else if (expZero) begin
            info.cls = CLS_DENORMAL;
        end else if (expOnes && fracZero) begin
            info.cls = CLS_INFINITY;
        end else if (expOnes) begin
            if (word == INDEF_WORD) begin
                info.cls = CLS_INDEFINITE;
            end else if (word.frac[QUIET_POS]) begin
                info.cls = CLS_QNAN;
            end else begin
                info.cls = CLS_SNAN;
            end
        end else begin
            info.cls = CLS_NORMAL;
        end
    end

endmodule : fp_classify

// file: hw/fp_single_classify_denormalize.sv
/*
 * Single-precision classify and normalize/denormalize unit.
 * Takes a source operand to classify and a raw result (sign, signed
 * true exponent, significand with explicit integer bit) to encode.
 * Assumes the arithmetic pipeline drives inputs synchronous to clk.
 */
// Behaviour
// - Sign zero positive, one negative
// - Significand: integer bit plus fraction, implied
// - Single precision bias is plus 127
// - Stored exponent is true plus bias
// - Biased 1 to 254 is normal
// - Normalize: strip leading zeros, decrement exponent
// - Zero exponent nonzero fraction is denormal
// - Plus and minus zero compare equal
// - Below -126 shift right to -126
// - All bits shifted out gives zero
// - Normal whenever range allows, else denormal
// - Underflow flag on denormal result creation
// - Denormal-operand flag on denormal source
// - Exactly one class per encoding
// - Infinity: exponent 255, zero fraction
// - Max exponent nonzero fraction is NaN
// - Top fraction bit set means quiet
`timescale 1ns/1ns
module fp_single_classify_denormalize
    import fp_single_pkg::*;
#(
    parameter int SIG_W = 24,      // Raw significand width, integer bit on top
    parameter int TEXP_W = 10      // Signed true exponent width
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic inValid,                 // Operand and raw result valid
    input wire logic [31:0] operand,          // Source operand to classify
    input wire logic [31:0] compareOperand,   // Second source for equality
    input wire logic resSign,                 // Raw result sign
    input wire logic signed [TEXP_W-1:0] resExp,  // Raw result true exponent
    input wire logic [SIG_W-1:0] resSig,      // Raw result significand
    output logic outValid,                    // Results valid
    output fp_class_t operandClass,           // Class of operand
    output logic operandNegative,             // Operand sign
    output logic operandsEqual,               // Operands equal in value
    output logic [31:0] result,               // Encoded result word
    output fp_class_t resultClass,            // Class of result word
    output logic underflowFlag,               // Denormal result created
    output logic denormalOperandFlag          // A source was denormal
);

    // --------------------------------------------------------------
    // Parameter checks
    // --------------------------------------------------------------
    // Refuse widths the datapath cannot serve
    if (SIG_W != FRAC_W + 1) begin : gBadSig
        $error("SIG_W must be fraction width plus one");
    end
    if (TEXP_W < EXP_W + 2 || TEXP_W > 16) begin : gBadExp
        $error("TEXP_W out of range");
    end

    localparam int SH_W = 5;   // Shift amount width, covers SIG_W

    // --------------------------------------------------------------
    // Operand classification
    // --------------------------------------------------------------
    fp_info_t opInfo;     // Info for first source
    fp_info_t cmpInfo;    // Info for second source
    fp_info_t resInfo;    // Info for encoded result

    fp_classify uClassOp (
        .word(fp_word_t'(operand)),
        .info(opInfo)
    );

    fp_classify uClassCmp (
        .word(fp_word_t'(compareOperand)),
        .info(cmpInfo)
    );

    // --------------------------------------------------------------
    // Normalization: leading zero count
    // --------------------------------------------------------------
    logic [SH_W-1:0] leadZeros;   // Leading zeros of resSig
    logic sigZero;                // Raw significand is zero

    assign sigZero = (resSig == SIG_W'(0));

    // Scan up from bit 0; the highest set bit wins
    always_comb begin
        leadZeros = SH_W'(0);
        for (int i = 0; i < SIG_W; i++) begin
            if (resSig[i]) begin
                leadZeros = SH_W'(SIG_W - 1 - i);
            end
        end
    end

    // --------------------------------------------------------------
    // Exponent and significand adjust
    // --------------------------------------------------------------
    logic signed [TEXP_W:0] normExp;     // True exponent after normalizing
    logic signed [TEXP_W:0] biasedExp;   // Exponent plus bias
    logic [SIG_W-1:0] normSig;           // Significand with integer bit set
    logic [SIG_W-1:0] outSig;            // Significand after denormalizing
    logic [TEXP_W:0] shiftNeed;          // Right shift to reach -126
    logic makesDenormal;                 // Result goes denormal
    logic [31:0] next_result;            // Encoded result word

    assign normSig = resSig << leadZeros;
    assign normExp = (TEXP_W+1)'(resExp) - (TEXP_W+1)'(signed'({1'b0, leadZeros}));
    assign biasedExp = normExp + (TEXP_W+1)'(EXP_BIAS);
    assign shiftNeed = (TEXP_W+1)'(TRUE_MIN) - normExp;

    // Encode the result word
    always_comb begin
        outSig = normSig;
        makesDenormal = 1'b0;
        next_result = {resSign, 31'h00000000};
        if (sigZero) begin
            // Exact zero keeps its sign
            next_result = {resSign, 31'h00000000};
        end else if (biasedExp > (TEXP_W+1)'(NORM_MAX)) begin
            // Overflow: signed infinity
            next_result = {resSign, EXP_W'(EXP_MAX), FRAC_W'(0)};
        end else if (biasedExp >= (TEXP_W+1)'(NORM_MIN)) begin
            next_result = {resSign, biasedExp[EXP_W-1:0], normSig[FRAC_W-1:0]};
        end else begin
            if (shiftNeed >= (TEXP_W+1)'(SIG_W)) begin
                outSig = SIG_W'(0);
            end else begin
                outSig = normSig >> shiftNeed;
            end
            makesDenormal = (outSig != SIG_W'(0));
            next_result = {resSign, EXP_W'(0), outSig[FRAC_W-1:0]};
        end
    end

    fp_classify uClassRes (
        .word(fp_word_t'(result)),
        .info(resInfo)
    );
    assign resultClass = resInfo.cls;

    // --------------------------------------------------------------
    // Registered outputs
    // --------------------------------------------------------------
    // Valid pipeline stage
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            outValid <= 1'b0;
        end else begin
            outValid <= inValid;
        end
    end

    // Operand class and comparison
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            operandClass <= CLS_ZERO;
            operandNegative <= 1'b0;
            operandsEqual <= 1'b0;
        end else if (inValid) begin
            operandClass <= opInfo.cls;
            operandNegative <= opInfo.negative;
            if (opInfo.isNan || cmpInfo.isNan) begin
                operandsEqual <= 1'b0;
            end else if (opInfo.isZero && cmpInfo.isZero) begin
                operandsEqual <= 1'b1;
            end else begin
                operandsEqual <= (operand == compareOperand);
            end
        end
    end

    // Result word
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            result <= RESULT_RST;
        end else if (inValid) begin
            result <= next_result;
        end
    end

    // Exception flags, per operation
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            underflowFlag <= 1'b0;
            denormalOperandFlag <= 1'b0;
        end else if (inValid) begin
            underflowFlag <= makesDenormal;
            denormalOperandFlag <= (opInfo.cls == CLS_DENORMAL)
                || (cmpInfo.cls == CLS_DENORMAL);
        end else begin
            underflowFlag <= 1'b0;
            denormalOperandFlag <= 1'b0;
        end
    end

endmodule : fp_single_classify_denormalize

// file: bench/fp_single_classify_denormalize_sva.sv
/*
 * Port checker for the classify and denormalize unit.
 * Assumes one clock, clk, and asynchronous active-low reset rst_n.
 */
`timescale 1ns/1ns
module fp_single_classify_denormalize_chk
    import fp_single_pkg::*;
#(
    parameter int SIG_W = 24,
    parameter int TEXP_W = 10
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic inValid,
    input wire logic [31:0] operand,
    input wire logic [31:0] compareOperand,
    input wire logic resSign,
    input wire logic signed [TEXP_W-1:0] resExp,
    input wire logic [SIG_W-1:0] resSig,
    input wire logic outValid,
    input wire fp_class_t operandClass,
    input wire logic operandNegative,
    input wire logic operandsEqual,
    input wire logic [31:0] result,
    input wire fp_class_t resultClass,
    input wire logic underflowFlag,
    input wire logic denormalOperandFlag
);
    // ----------------------------------------
    // Clocking and field helpers
    // ----------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    wire logic [7:0] opExp = operand[30:23];   // Operand exponent field
    wire logic [7:0] cmpExp = compareOperand[30:23];   // Second exponent field

    a_valid_follows: assert property (inValid |=> outValid) else $error("no valid");
    a_valid_idle: assert property (!inValid |=> !outValid) else $error("stray valid");
    a_result_holds: assert property (!inValid |=> $stable(result)) else $error("result moved");
    a_flags_pulse: assert property ((underflowFlag || denormalOperandFlag) |-> outValid)
        else $error("flag without valid");
    a_under_class: assert property (underflowFlag |-> resultClass == CLS_DENORMAL)
        else $error("underflow not denormal");
    a_denorm_seen: assert property (inValid && opExp == 8'h00 && operand[22:0] != 0
        |=> denormalOperandFlag) else $error("denormal operand missed");
    a_denorm_none: assert property (inValid && opExp != 8'h00 && cmpExp != 8'h00
        |=> !denormalOperandFlag) else $error("false denormal flag");
    a_sign_read: assert property (inValid |=> operandNegative == $past(operand[31]))
        else $error("sign wrong");
    a_normal_range: assert property (inValid && opExp >= 8'h01 && opExp <= 8'hFE
        |=> operandClass == CLS_NORMAL) else $error("normal class wrong");
    a_inf_class: assert property (inValid && opExp == 8'hFF && operand[22:0] == 0
        |=> operandClass == CLS_INFINITY) else $error("infinity class wrong");
    a_snan_class: assert property (inValid && opExp == 8'hFF && !operand[22] && operand[21:0] != 0
        |=> operandClass == CLS_SNAN) else $error("signaling class wrong");
    a_zero_equal: assert property (inValid && operand[30:0] == 0 && compareOperand[30:0] == 0
        |=> operandsEqual) else $error("zeros unequal");

    c_underflow: cover property (underflowFlag);
    c_denorm_op: cover property (denormalOperandFlag);
    c_back2back: cover property (outValid [*3]);
endmodule : fp_single_classify_denormalize_chk

bind fp_single_classify_denormalize fp_single_classify_denormalize_chk #(
    .SIG_W(SIG_W), .TEXP_W(TEXP_W)) chk_u (
    .clk(clk), .rst_n(rst_n), .inValid(inValid), .operand(operand),
    .compareOperand(compareOperand), .resSign(resSign), .resExp(resExp), .resSig(resSig),
    .outValid(outValid), .operandClass(operandClass), .operandNegative(operandNegative),
    .operandsEqual(operandsEqual), .result(result), .resultClass(resultClass),
    .underflowFlag(underflowFlag), .denormalOperandFlag(denormalOperandFlag));

// file: bench/fp_result_sink.sv
/*
 * Downstream pipeline stage model: takes each valid result word.
 * Assumes results arrive one cycle after each accepted request.
 */
`timescale 1ns/1ns
module fp_result_sink (
    input wire logic clk,
    input wire logic outValid,
    input wire logic [31:0] result,
    output int nResults,
    output logic [31:0] lastResult
);
    initial nResults = 0;
    initial lastResult = 32'h00000000;   // Last word consumed
    // Consume one word per valid cycle
    always @(posedge clk) begin
        if (outValid) begin
            nResults <= nResults + 1;
            lastResult <= result;
        end
    end
endmodule : fp_result_sink

// file: bench/fp_single_classify_denormalize_tb_top.sv
/*
 * Self-checking bench: directed, random and reset cases against a model.
 * Assumes the design package and a 100 MHz clock.
 */
`timescale 1ns/1ns
module fp_single_classify_denormalize_tb_top;
    import fp_single_pkg::*;
    logic clk = 0, rst_n = 0, inValid = 0, resSign = 0, pend = 0;
    logic [31:0] operand = 0, compareOperand = 0, result, eA, eB, a, b, lastResult;
    logic signed [9:0] resExp = 0;
    logic [23:0] resSig = 0;
    logic outValid, operandsEqual, operandNegative, underflowFlag, denormalOperandFlag;
    fp_class_t operandClass, resultClass;
    logic [32:0] eR;   // Expected flag and word
    logic [31:0] rnd = 32'h0000000A;   // Random state
    int fails = 0, nTests = 0, nSent = 0, nResults;

    always #5 clk = ~clk;

    fp_single_classify_denormalize dut_u (.clk(clk), .rst_n(rst_n), .inValid(inValid),
        .operand(operand), .compareOperand(compareOperand), .resSign(resSign),
        .resExp(resExp), .resSig(resSig), .outValid(outValid), .operandClass(operandClass),
        .operandNegative(operandNegative), .operandsEqual(operandsEqual), .result(result),
        .resultClass(resultClass), .underflowFlag(underflowFlag),
        .denormalOperandFlag(denormalOperandFlag));
    fp_result_sink sink_u (.clk(clk), .outValid(outValid), .result(result), .nResults(nResults),
        .lastResult(lastResult));

    // ----------------------------------------
    // Model
    // ----------------------------------------
    function logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction : lfsr
    function logic isDen(input logic [31:0] w);
        return w[30:23] == 8'h00 && w[22:0] != 0;
    endfunction : isDen
    function logic isNan(input logic [31:0] w);
        return w[30:23] == 8'hFF && w[22:0] != 0;
    endfunction : isNan
    function fp_class_t mcls(input logic [31:0] w);
        if (w[30:23] == 8'h00) return (w[22:0] == 0) ? CLS_ZERO : CLS_DENORMAL;
        if (w[30:23] != 8'hFF) return CLS_NORMAL;
        if (w[22:0] == 0) return CLS_INFINITY;
        if (w == 32'hFFC00000) return CLS_INDEFINITE;
        return w[22] ? CLS_QNAN : CLS_SNAN;
    endfunction : mcls
    function logic meq(input logic [31:0] x, input logic [31:0] y);
        if (isNan(x) || isNan(y)) return 1'b0;
        if (x[30:0] == 0 && y[30:0] == 0) return 1'b1;
        return x == y;
    endfunction : meq
    function logic [32:0] menc(input logic s, input int e, input logic [23:0] g);
        int bx;
        logic [23:0] m;
        if (g == 0) return {1'b0, s, 31'h0};
        m = g;
        bx = e + 127;
        while (!m[23]) begin
            m = m << 1;
            bx = bx - 1;
        end
        if (bx > 254) return {1'b0, s, 8'hFF, 23'h0};
        if (bx >= 1) return {1'b0, s, bx[7:0], m[22:0]};
        m = (1 - bx > 24) ? 24'h0 : m >> (1 - bx);
        return {m != 0, s, 8'h00, m[22:0]};
    endfunction : menc

    task chk(input string what, input logic [31:0] seen, input logic [31:0] want);
        nTests++;
        if (seen !== want) begin
            fails++;
            $display("unexpected %s expected %h seen %h", what, want, seen);
        end
    endtask : chk
    task check_pend;
        if (pend) begin
            chk("outValid", outValid, 1);
            chk("operandClass", operandClass, mcls(eA));
            chk("operandNegative", operandNegative, eA[31]);
            chk("operandsEqual", operandsEqual, meq(eA, eB));
            chk("result", result, eR[31:0]);
            chk("resultClass", resultClass, mcls(eR[31:0]));
            chk("underflowFlag", underflowFlag, eR[32]);
            chk("denormalOperandFlag", denormalOperandFlag, isDen(eA) | isDen(eB));
        end
    endtask : check_pend
    task op(input logic [31:0] x, input logic [31:0] y, input logic s, input int e,
            input logic [23:0] g);
        @(posedge clk);
        inValid <= 1;
        operand <= x;
        compareOperand <= y;
        resSign <= s;
        resExp <= e[9:0];
        resSig <= g;
        #1 check_pend;
        pend = 1;
        eA = x;
        eB = y;
        eR = menc(s, e, g);
        nSent++;
    endtask : op
    task idle;
        @(posedge clk);
        inValid <= 0;
        #1 if (!pend) chk("outValid", outValid, 0);
        check_pend;
        pend = 0;
    endtask : idle
    task complete_run;
        $display("tests %0d fails %0d", nTests, fails);
        if (fails == 0 && nTests > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : complete_run

    initial begin
        #400000 fails++;
        complete_run;
    end

    initial begin
        repeat (2) @(posedge clk);
        rst_n <= 1;
        op(32'h00000001, 32'h3F800000, 0, -129, 24'hAE0000);
        op(32'h80000000, 32'h00000000, 1, -126, 24'h800000);
        op(32'h7F800000, 32'h7F800000, 0, -127, 24'h800000);
        op(32'h7FC00001, 32'h7FC00001, 1, -149, 24'h800000);
        op(32'h7F800001, 32'h00000000, 0, -150, 24'h800000);
        op(32'hFFC00000, 32'h807FFFFF, 0, 127, 24'hFFFFFF);
        op(32'h3F800000, 32'h3F800000, 1, 128, 24'h800000);
        op(32'h00800000, 32'h7F7FFFFF, 0, 5, 24'h000001);
        op(32'hFF7FFFFF, 32'h00000000, 1, 0, 24'h000000);
        op(32'h00400000, 32'h80000000, 0, -120, 24'h000003);
        idle;
        $display("directed done");
        repeat (300) begin
            rnd = lfsr(rnd);
            a = rnd[5] ? {rnd[31], 8'h00, rnd[22:0]} : rnd;
            rnd = lfsr(rnd);
            b = rnd;
            rnd = lfsr(rnd);
            if (rnd[1:0] == 2'h0) idle;
            else op(a, b, rnd[31], int'(rnd[9:2]) - 200, rnd[31:8] >> rnd[4:0]);
        end
        idle;
        $display("random done");
        op(32'h00000001, 32'h00000001, 0, -129, 24'hAE0000);
        @(posedge clk);
        rst_n <= 0;
        inValid <= 0;
        #1 chk("result", result, 32'h00000000);
        chk("outValid", outValid, 0);
        chk("operandClass", operandClass, CLS_ZERO);
        pend = 0;
        nSent--;
        @(posedge clk);
        rst_n <= 1;
        op(32'h00000001, 32'h00000000, 0, -129, 24'hAE0000);
        idle;
        $display("reset done");
        // Sink takes the last word one edge after it appears
        @(posedge clk);
        #1 chk("nResults", nResults, nSent);
        chk("lastResult", lastResult, eR[31:0]);
        complete_run;
    end
endmodule : fp_single_classify_denormalize_tb_top
